/* src/sfsr_pkg.sv */
package sfsr_pkg;

	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int WORD_W = 16;
	localparam int ADDR_W = 4;
	localparam int NUM_CH = 5;
	localparam int NUM_IN = 4;
	localparam int OC_W = 3;
	localparam int CNT_W = 5;
	localparam int ID_W = 8;
	localparam int FB_W = 3;
	localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;

	// ---------------------------------------------------------------
	// Status word addresses (also the code in bits 15..12, except SO_INIT, which returns code 0001)
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] SO_INIT = 4'h0;
	localparam logic [ADDR_W-1:0] SO_QUICK = 4'h1;
	localparam logic [ADDR_W-1:0] SO_CH_FIRST = 4'h2;
	localparam logic [ADDR_W-1:0] SO_DEVICE = 4'h7;
	localparam logic [ADDR_W-1:0] SO_IO = 4'h8;
	localparam logic [ADDR_W-1:0] SO_ID = 4'h9;

	// ---------------------------------------------------------------
	// Status word bit positions
	// ---------------------------------------------------------------
	localparam int ADDR_LSB = 12;
	localparam int FAIL_BIT = 11;
	localparam int DEV_SUM_BIT = 10;
	localparam int OVERLOAD_BIT = 9;
	localparam int OPENLOAD_BIT = 8;

	// ---------------------------------------------------------------
	// Initialization register 0 layout in the incoming command word
	// ---------------------------------------------------------------
	localparam int CMD_ADDR_LSB = 0;
	localparam int CMD_PERSIST_BIT = 4;
	localparam int CMD_FB_LSB = 5;

	// ---------------------------------------------------------------
	// Overcurrent codes
	// ---------------------------------------------------------------
	localparam logic [OC_W-1:0] OC_NONE = 3'h0;
	localparam logic [OC_W-1:0] OC_HI1 = 3'h1;
	localparam logic [OC_W-1:0] OC_HI2 = 3'h2;
	localparam logic [OC_W-1:0] OC_HI3 = 3'h3;
	localparam logic [OC_W-1:0] OC_LO = 3'h4;
	localparam logic [OC_W-1:0] OC_HI_OD = 3'h5;
	localparam logic [OC_W-1:0] OC_SEVERE = 3'h6;

	// Frame tracker states
	typedef enum logic [1:0] {
		SFSR_IDLE = 2'b01,
		SFSR_FRAME = 2'b10
	} sfsr_state_e;

endpackage

/* src/sfsr_readout.sv */
`timescale 1ns/1ps

// Operation
// - Serial output returns the word chosen by so_address_select in register 0.
// - With persist clear, programmed address serves one read, then quick status returns.
// - With persist set, programmed address serves every read until reprogrammed.
// - Bit 11 of every word shows fail mode.
// - Global flags bits 10..8 appear in words 1-7, clear when faults read away.
// - Device summary is OR of cleared, undervoltage, overvoltage, pump, clock, test flags.
// - Bit 9 ORs overcurrent and overtemp shutdown; bit 8 shows any openload.
// - Quick word holds pump fault, registers cleared, clock fault in bits 7..5.
// - Quick bits 4..0 OR each channel's latched fault bits.
// - Address 0 returns quick status carrying code 0001.
// - Channel words 2-6 carry shutdown, warning, overcurrent code, openload flags.
// - Overcurrent code holds the most recent fault, overwriting older unread one.
// - Device word 7 holds test, overvoltage, undervoltage, serial fault, limp input.
// - Limp home bit is live after synchronising, never latched.
// - Word 8 holds toggle, input pins and output levels, all live.
// - Toggle bit is live OR of four toggle-on signals.
// - Output level bits are meaningful only without undervoltage.
// - Word 9 holds part identifier, zero while undervoltage flag set.
// - Analog feedback active only in normal mode, source from feedback_select.
// - Latched channel diagnosis released only by reading that channel word.
module sfsr_readout #(
	parameter logic [sfsr_pkg::ID_W-1:0] PART_ID = 8'hA5 // Arbitrary value
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic spi_clk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire logic fail_mode,
	input wire logic sleep_mode,
	input wire logic [sfsr_pkg::NUM_CH-1:0] oc_event,
	input wire logic [sfsr_pkg::NUM_CH*sfsr_pkg::OC_W-1:0] oc_code_in,
	input wire logic [sfsr_pkg::NUM_CH-1:0] ots_event,
	input wire logic [sfsr_pkg::NUM_CH-1:0] otw_event,
	input wire logic [sfsr_pkg::NUM_CH-1:0] olon_event,
	input wire logic [sfsr_pkg::NUM_CH-1:0] oloff_event,
	input wire logic cp_fault_event,
	input wire logic clk_fault_event,
	input wire logic uv_event,
	input wire logic ov_event,
	input wire logic test_mode_event,
	input wire logic [sfsr_pkg::NUM_IN-1:0] toggle_on,
	input wire logic limp_home_pin,
	input wire logic [sfsr_pkg::NUM_IN-1:0] input_pin,
	input wire logic [sfsr_pkg::NUM_CH-1:0] output_pin,
	output logic [sfsr_pkg::ADDR_W-1:0] so_address_select,
	output logic read_address_persist,
	output logic [sfsr_pkg::FB_W-1:0] feedback_select,
	output logic feedback_enable
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam int PIN_W = 3 + 1 + sfsr_pkg::NUM_IN + sfsr_pkg::NUM_CH;
	localparam logic [PIN_W-1:0] PIN_RST = {1'b1, {(PIN_W-1){1'b0}}};

	logic [PIN_W-1:0] pins_s;
	logic cs_n_s, sclk_s, mosi_s, limp_home_input;
	logic [sfsr_pkg::NUM_IN-1:0] input_pin_status;
	logic [sfsr_pkg::NUM_CH-1:0] output_pin_level;
	logic prev_cs_n, prev_sclk;
	logic cs_fall, cs_rise, sclk_rise, sclk_fall;
	sfsr_pkg::sfsr_state_e state;
	logic [sfsr_pkg::CNT_W-1:0] bit_cnt;
	logic [sfsr_pkg::WORD_W-1:0] rx_shift, tx_shift, next_word;
	logic [sfsr_pkg::ADDR_W-1:0] frame_addr;
	logic frame_end, frame_ok, read_clear, is_init_cmd;
	logic [sfsr_pkg::NUM_CH-1:0] clr_ch, ots_l, otw_l, olon_l, oloff_l;
	logic [sfsr_pkg::NUM_CH-1:0] channel_quick_flags;
	logic [sfsr_pkg::NUM_CH-1:0][sfsr_pkg::OC_W-1:0] oc_l;
	logic clr_dev;
	logic charge_pump_fault, registers_cleared_flag, clock_fault_flag;
	logic undervoltage_flag, overvoltage_flag, test_mode_flag, serial_fault_flag;
	logic device_fault_summary, overload_summary, openload_summary;
	logic [2:0] global_flags;

	// Address code of a channel word
	function automatic logic [sfsr_pkg::ADDR_W-1:0] ch_addr(input int idx);
		ch_addr = sfsr_pkg::SO_CH_FIRST + idx[sfsr_pkg::ADDR_W-1:0];
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	sfsr_sync #(
		.WIDTH(PIN_W),
		.RESET_VAL(PIN_RST)
	) u_sync (
		.core_clk(core_clk),
		.reset(reset),
		.async_in({spi_cs_n, spi_clk, spi_mosi, limp_home_pin, input_pin, output_pin}),
		.sync_out(pins_s)
	);

	// Split synchronised pins
	assign {cs_n_s, sclk_s, mosi_s, limp_home_input, input_pin_status, output_pin_level} = pins_s;

	// ---------------------------------------------------------------
	// SPI edge detection
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prev_cs_n <= 1'b1;
			prev_sclk <= 1'b0;
		end else begin
			prev_cs_n <= cs_n_s;
			prev_sclk <= sclk_s;
		end
	end

	// Edge strobes
	assign cs_fall = prev_cs_n & ~cs_n_s;
	assign cs_rise = ~prev_cs_n & cs_n_s;
	assign sclk_rise = ~prev_sclk & sclk_s & ~cs_n_s;
	assign sclk_fall = prev_sclk & ~sclk_s & ~cs_n_s;
	assign frame_end = cs_rise & (state == sfsr_pkg::SFSR_FRAME);
	assign frame_ok = frame_end & (bit_cnt == sfsr_pkg::FRAME_BITS);
	assign read_clear = frame_ok;
	assign is_init_cmd = rx_shift[sfsr_pkg::WORD_W-1 -: sfsr_pkg::ADDR_W] == sfsr_pkg::SO_INIT;

	// ---------------------------------------------------------------
	// Frame tracking and shift registers
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= sfsr_pkg::SFSR_IDLE;
			bit_cnt <= '0;
			rx_shift <= '0;
			tx_shift <= '0;
			frame_addr <= sfsr_pkg::SO_QUICK;
		end else begin
			case (state)
				sfsr_pkg::SFSR_IDLE: begin
					if (cs_fall) begin
						state <= sfsr_pkg::SFSR_FRAME;
						bit_cnt <= '0;
						tx_shift <= next_word;
						frame_addr <= so_address_select;
					end
				end
				sfsr_pkg::SFSR_FRAME: begin
					if (cs_rise) begin
						state <= sfsr_pkg::SFSR_IDLE;
					end else begin
						if (sclk_rise) begin
							rx_shift <= {rx_shift[sfsr_pkg::WORD_W-2:0], mosi_s};
							if (bit_cnt != {sfsr_pkg::CNT_W{1'b1}}) begin
								bit_cnt <= bit_cnt + 5'h01;
							end
						end
						if (sclk_fall) begin
							tx_shift <= {tx_shift[sfsr_pkg::WORD_W-2:0], 1'b0};
						end
					end
				end
				default: begin
					state <= sfsr_pkg::SFSR_IDLE;
				end
			endcase
		end
	end

	// Serial output driven from a flop, enabled while selected
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			spi_miso <= tx_shift[sfsr_pkg::WORD_W-1];
			spi_miso_oe <= ~cs_n_s & (state == sfsr_pkg::SFSR_FRAME);
		end
	end

	// ---------------------------------------------------------------
	// Initialization register 0 and address selection
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			so_address_select <= sfsr_pkg::SO_QUICK;
			read_address_persist <= 1'b0;
			feedback_select <= '0;
		end else if (frame_ok) begin
			if (is_init_cmd) begin
				so_address_select <= rx_shift[sfsr_pkg::CMD_ADDR_LSB +: sfsr_pkg::ADDR_W];
				read_address_persist <= rx_shift[sfsr_pkg::CMD_PERSIST_BIT];
				feedback_select <= rx_shift[sfsr_pkg::CMD_FB_LSB +: sfsr_pkg::FB_W];
			end else if (!read_address_persist) begin
				so_address_select <= sfsr_pkg::SO_QUICK;
			end
		end
	end

	// Feedback only in normal mode
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			feedback_enable <= 1'b0;
		end else begin
			feedback_enable <= ~fail_mode & ~sleep_mode;
		end
	end

	// ---------------------------------------------------------------
	// Channel latches, cleared by reading their word
	// ---------------------------------------------------------------
	for (genvar c = 0; c < sfsr_pkg::NUM_CH; c++) begin : g_ch
		assign clr_ch[c] = read_clear & (frame_addr == ch_addr(c));

		// New events win over a read clear in the same cycle
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				oc_l[c] <= sfsr_pkg::OC_NONE;
				ots_l[c] <= 1'b0;
				otw_l[c] <= 1'b0;
				olon_l[c] <= 1'b0;
				oloff_l[c] <= 1'b0;
			end else begin
				if (oc_event[c]) begin
					oc_l[c] <= oc_code_in[c*sfsr_pkg::OC_W +: sfsr_pkg::OC_W];
				end else if (clr_ch[c]) begin
					oc_l[c] <= sfsr_pkg::OC_NONE;
				end
				ots_l[c] <= ots_event[c] | (ots_l[c] & ~clr_ch[c]);
				otw_l[c] <= otw_event[c] | (otw_l[c] & ~clr_ch[c]);
				olon_l[c] <= olon_event[c] | (olon_l[c] & ~clr_ch[c]);
				oloff_l[c] <= oloff_event[c] | (oloff_l[c] & ~clr_ch[c]);
			end
		end

		// Per-channel quick flag
		assign channel_quick_flags[c] = (|oc_l[c]) | otw_l[c] | ots_l[c] |
			olon_l[c] | oloff_l[c];
	end

	// ---------------------------------------------------------------
	// Device latches, cleared by reading the device word
	// ---------------------------------------------------------------
	assign clr_dev = read_clear & (frame_addr == sfsr_pkg::SO_DEVICE);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			registers_cleared_flag <= 1'b1;
			charge_pump_fault <= 1'b0;
			clock_fault_flag <= 1'b0;
			undervoltage_flag <= 1'b0;
			overvoltage_flag <= 1'b0;
			test_mode_flag <= 1'b0;
		end else begin
			registers_cleared_flag <= registers_cleared_flag & ~clr_dev;
			charge_pump_fault <= cp_fault_event | (charge_pump_fault & ~clr_dev);
			clock_fault_flag <= clk_fault_event | (clock_fault_flag & ~clr_dev);
			undervoltage_flag <= uv_event | (undervoltage_flag & ~clr_dev);
			overvoltage_flag <= ov_event | (overvoltage_flag & ~clr_dev);
			test_mode_flag <= test_mode_event | (test_mode_flag & ~clr_dev);
		end
	end

	// Bad frame length marks a serial fault
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			serial_fault_flag <= 1'b0;
		end else begin
			serial_fault_flag <= (frame_end & ~frame_ok) | (serial_fault_flag & ~clr_dev);
		end
	end

	// ---------------------------------------------------------------
	// Global summaries
	// ---------------------------------------------------------------
	assign device_fault_summary = registers_cleared_flag | undervoltage_flag | overvoltage_flag |
		charge_pump_fault | clock_fault_flag | test_mode_flag;
	assign overload_summary = (|oc_l) | (|ots_l);
	assign openload_summary = (|olon_l) | (|oloff_l);
	assign global_flags = {device_fault_summary, overload_summary, openload_summary};

	// ---------------------------------------------------------------
	// Status word assembly
	// ---------------------------------------------------------------
	always_comb begin
		next_word = {sfsr_pkg::SO_QUICK, fail_mode, global_flags, charge_pump_fault,
			registers_cleared_flag, clock_fault_flag, channel_quick_flags};
		case (so_address_select)
			sfsr_pkg::SO_INIT, sfsr_pkg::SO_QUICK: begin
				next_word = {sfsr_pkg::SO_QUICK, fail_mode, global_flags, charge_pump_fault,
					registers_cleared_flag, clock_fault_flag, channel_quick_flags};
			end
			sfsr_pkg::SO_DEVICE: begin
				next_word = {sfsr_pkg::SO_DEVICE, fail_mode, global_flags, 3'h0, test_mode_flag,
					overvoltage_flag, undervoltage_flag, serial_fault_flag,
					limp_home_input};
			end
			sfsr_pkg::SO_IO: begin
				next_word = {sfsr_pkg::SO_IO, fail_mode, 1'b0, |toggle_on, input_pin_status,
					output_pin_level};
			end
			sfsr_pkg::SO_ID: begin
				next_word = {sfsr_pkg::SO_ID, fail_mode, 3'h0,
					undervoltage_flag ? 8'h00 : PART_ID};
			end
			default: begin
				for (int k = 0; k < sfsr_pkg::NUM_CH; k++) begin
					if (so_address_select == ch_addr(k)) begin
						next_word = {ch_addr(k), fail_mode, global_flags, 1'b0, ots_l[k],
							otw_l[k], oc_l[k], olon_l[k], oloff_l[k]};
					end
				end
			end
		endcase
		next_word[sfsr_pkg::FAIL_BIT] = fail_mode;
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	localparam int WATCH_CH = 2; // Channel three: the one the bench faults twice and reads

	AST_LOAD_SELECTED: assert property (cs_fall && state == sfsr_pkg::SFSR_IDLE |=>
		frame_addr == $past(so_address_select) && tx_shift == $past(next_word))
		else $error("frame did not load the selected word");
	AST_ONE_SHOT: assert property (frame_ok && !is_init_cmd && !read_address_persist |=>
		so_address_select == sfsr_pkg::SO_QUICK)
		else $error("single-read address did not revert");
	AST_PERSIST: assert property (frame_ok && !is_init_cmd && read_address_persist |=>
		$stable(so_address_select))
		else $error("persistent address changed");
	AST_FAIL_BIT: assert property (cs_fall && state == sfsr_pkg::SFSR_IDLE |=>
		tx_shift[sfsr_pkg::FAIL_BIT] == $past(fail_mode))
		else $error("fail mode bit wrong");
	AST_GLOBAL: assert property (cs_fall && state == sfsr_pkg::SFSR_IDLE &&
		so_address_select == sfsr_pkg::SO_DEVICE |=>
		tx_shift[sfsr_pkg::DEV_SUM_BIT:sfsr_pkg::OPENLOAD_BIT] == $past(global_flags))
		else $error("global flags missing from device word");
	AST_OC_LATEST: assert property (oc_event[WATCH_CH] |=>
		oc_l[WATCH_CH] == $past(oc_code_in[WATCH_CH*sfsr_pkg::OC_W +: sfsr_pkg::OC_W]))
		else $error("overcurrent code not the latest");
	AST_READ_CLEAR: assert property (clr_ch[WATCH_CH] && !oc_event[WATCH_CH] &&
		!ots_event[WATCH_CH] && !otw_event[WATCH_CH] && !olon_event[WATCH_CH] &&
		!oloff_event[WATCH_CH] |=> oc_l[WATCH_CH] == sfsr_pkg::OC_NONE && !ots_l[WATCH_CH] &&
		!otw_l[WATCH_CH] && !olon_l[WATCH_CH] && !oloff_l[WATCH_CH])
		else $error("channel read did not clear latches");
	AST_ID_UV: assert property (cs_fall && state == sfsr_pkg::SFSR_IDLE && undervoltage_flag &&
		so_address_select == sfsr_pkg::SO_ID |=> tx_shift[sfsr_pkg::ID_W-1:0] == 8'h00)
		else $error("identifier not zero under undervoltage");
	AST_SPI_FAULT: assert property (frame_end && bit_cnt != sfsr_pkg::FRAME_BITS |=>
		serial_fault_flag && $stable(so_address_select))
		else $error("bad frame not flagged");
	AST_FB_OFF: assert property (fail_mode || sleep_mode |=> !feedback_enable)
		else $error("feedback active outside normal mode");

endmodule // sfsr_readout

/* src/sfsr_sync.sv */
`timescale 1ns/1ps

// -------------------------------------------------------------------
// Two-stage synchroniser bank for pin inputs
// -------------------------------------------------------------------
module sfsr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage_one;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stage_one <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule // sfsr_sync

/* tb/sfsr_spi_master.sv */
`timescale 1ns/1ps

// ---------------------------------------------------------------
// Controller model: SPI mode 0, MSB first, clock still between frames
// ---------------------------------------------------------------
module sfsr_spi_master (
	output logic spi_clk,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso,
	input wire logic spi_miso_oe
);
	localparam realtime HALF = 62.5;

	// Idle: deselected, clock low
	initial begin
		spi_clk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// One frame of nbits clocks; fewer than 16 is a frame the design refuses
	task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
		rx = 16'h0000;
		spi_cs_n = 1'b0;
		for (int i = 0; i < nbits; i++) begin
			spi_mosi = tx[15-i];
			#HALF;
			spi_clk = 1'b1;
			rx[15-i] = spi_miso_oe ? spi_miso : 1'bx; // Undriven line never matches
			#HALF;
			spi_clk = 1'b0;
		end
		#HALF;
		spi_cs_n = 1'b1;
		spi_mosi = ~spi_mosi; // No stale data once released
		#HALF;
	endtask
endmodule // sfsr_spi_master

/* tb/test_spi_fault_status_readout.sv */
`timescale 1ns/1ps

module test_spi_fault_status_readout;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic fail_mode = 1'b0, sleep_mode = 1'b0, limp_home_pin = 1'b1;
	logic cp_fault_event = 1'b0, clk_fault_event = 1'b0, uv_event = 1'b0;
	logic ov_event = 1'b0, test_mode_event = 1'b0;
	logic [4:0] oc_event = '0, ots_event = '0, otw_event = '0, olon_event = '0;
	logic [4:0] oloff_event = '0, output_pin = '0;
	logic [14:0] oc_code_in = '0;
	logic [3:0] toggle_on = '0, input_pin = '0, so_address_select;
	logic read_address_persist, feedback_enable;
	logic [2:0] feedback_select;
	logic [15:0] rx_drop;
	wire spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
	int err_count = 0;
	int compares = 0;

	// ---------------------------------------------------------------
	// Clock, design and controller
	// ---------------------------------------------------------------
	always #2.5 core_clk = ~core_clk;

	// Identifier value is arbitrary
	sfsr_readout #(.PART_ID(8'h5C)) i_sfsr_readout (
		.core_clk(core_clk), .reset(reset),
		.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
		.fail_mode(fail_mode), .sleep_mode(sleep_mode),
		.oc_event(oc_event), .oc_code_in(oc_code_in),
		.ots_event(ots_event), .otw_event(otw_event),
		.olon_event(olon_event), .oloff_event(oloff_event),
		.cp_fault_event(cp_fault_event), .clk_fault_event(clk_fault_event),
		.uv_event(uv_event), .ov_event(ov_event), .test_mode_event(test_mode_event),
		.toggle_on(toggle_on), .limp_home_pin(limp_home_pin),
		.input_pin(input_pin), .output_pin(output_pin),
		.so_address_select(so_address_select),
		.read_address_persist(read_address_persist),
		.feedback_select(feedback_select), .feedback_enable(feedback_enable)
	);

	sfsr_spi_master i_sfsr_spi_master (
		.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
	);

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_field(input logic [3:0] got, input logic [3:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Full frame, compare the word shifted back
	task automatic frame(input logic [15:0] tx, input logic [15:0] exp);
		logic [15:0] rx;
		i_sfsr_spi_master.xfer(tx, 16, rx);
		chk_word(rx, exp);
	endtask

	task automatic do_reset;
		reset <= 1'b1;
		repeat (6) @(posedge core_clk);
		reset <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	task automatic clear_events;
		oc_event <= '0;
		ots_event <= '0;
		otw_event <= '0;
		olon_event <= '0;
		oloff_event <= '0;
		cp_fault_event <= 1'b0;
		clk_fault_event <= 1'b0;
		uv_event <= 1'b0;
		ov_event <= 1'b0;
		test_mode_event <= 1'b0;
	endtask

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Watchdog and test sequence
	// ---------------------------------------------------------------
	initial begin
		#200000;
		err_count++;
		stop_test();
	end

	initial begin
		do_reset();
		chk_field(so_address_select, 4'h1);
		frame(16'h0007, 16'h1440);
		frame(16'hF000, 16'h7401);
		frame(16'hF000, 16'h1000);
		// Faults on every channel, two overcurrents on channel 3
		@(posedge core_clk);
		fail_mode <= 1'b1;
		ov_event <= 1'b1;
		oc_code_in <= {6'h00, sfsr_pkg::OC_HI2, 6'h00};
		oc_event <= 5'h04;
		olon_event <= 5'h01;
		otw_event <= 5'h02;
		oloff_event <= 5'h08;
		ots_event <= 5'h10;
		@(posedge core_clk);
		clear_events();
		@(posedge core_clk);
		oc_code_in <= {6'h00, sfsr_pkg::OC_SEVERE, 6'h00};
		oc_event <= 5'h04;
		@(posedge core_clk);
		clear_events();
		repeat (3) @(posedge core_clk);
		frame(16'h00B4, 16'h1F1F);
		chk_field(so_address_select, 4'h4);
		chk_field({1'b0, feedback_select}, 4'h5);
		chk_field({3'h0, read_address_persist}, 4'h1);
		chk_field({3'h0, feedback_enable}, 4'h0);
		frame(16'hF000, 16'h4F18);
		frame(16'hF000, 16'h4F00);
		@(posedge core_clk);
		fail_mode <= 1'b0;
		toggle_on <= 4'h2;
		input_pin <= 4'hA;
		output_pin <= 5'h15;
		repeat (4) @(posedge core_clk);
		frame(16'h0018, 16'h4700);
		chk_field({3'h0, feedback_enable}, 4'h1);
		frame(16'h0009, 16'h8355);
		frame(16'hF000, 16'h905C);
		frame(16'h0009, 16'h171B);
		@(posedge core_clk);
		uv_event <= 1'b1;
		cp_fault_event <= 1'b1;
		clk_fault_event <= 1'b1;
		test_mode_event <= 1'b1;
		sleep_mode <= 1'b1;
		@(posedge core_clk);
		clear_events();
		repeat (3) @(posedge core_clk);
		chk_field({3'h0, feedback_enable}, 4'h0);
		sleep_mode <= 1'b0;
		frame(16'hF000, 16'h9000);
		// Short frame is refused
		i_sfsr_spi_master.xfer(16'h0007, 8, rx_drop);
		chk_field(so_address_select, 4'h1);
		frame(16'h0007, 16'h17BB);
		frame(16'hF000, 16'h771F);
		// Test mode seen set: controller resets the device
		do_reset();
		chk_field({3'h0, read_address_persist}, 4'h0);
		frame(16'h0000, 16'h1440);
		chk_field(so_address_select, 4'h0);
		frame(16'hF000, 16'h1440);
		stop_test();
	end
endmodule // test_spi_fault_status_readout
